/* src/ppsm_strap_mux.sv */
// Reset-strapped pin multiplexer for parallel port data and control pin zero
// Behaviour
// - Strap level at the first clock edge after reset release selects function of lower sixteen data pins.
// - Strap low: lower data pins carry the host port data bus.
// - Strap high: lower data pins carry external memory data bus low half.
// - Data pin function fixed when reset is released.
// - Strap low: upper data pins are parallel GPIO bits 4 to 19.
// - Strap high: upper data pins are external memory data high half.
// - Upper GPIO lines are inputs after reset.
// - All external memory data lines are inputs after reset.
// - Host port data lines are inputs after reset.
// - Strap low: host port runs non-multiplexed.
// - Non-multiplexed host port has separate 16-bit address and data buses.
// - Each host cycle carries one full 16-bit data word.
// - Bus holders keep floating lines at last driven level.
// - Holders on at reset, then switched by bus control setting.
// - Control pin zero is GPIO bit 20 or memory read strobe.
// - Control pin zero function fixed when reset is released.
// - Control pin zero as GPIO bit 20 is input after reset.
// - Memory strobe on control pin zero floats in reset, then drives 1.
// - Strap low: address pins form the 16-bit host port address bus.
`timescale 1ns/100ps
module ppsm_strap_mux (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mode_strap_pin,
    input wire logic holder_enable_set,
    input wire logic [ppsm_pkg::DATA_W-1:0] data_pin_in,
    output logic [ppsm_pkg::DATA_W-1:0] data_pin_out,
    output logic [ppsm_pkg::DATA_W-1:0] data_pin_oe_n,
    output logic [ppsm_pkg::DATA_W-1:0] data_keep_val,
    output logic [ppsm_pkg::DATA_W-1:0] data_keep_on,
    input wire logic ctrl_pin_in,
    output logic ctrl_pin_out,
    output logic ctrl_pin_oe_n,
    input wire logic [ppsm_pkg::ADDR_W-1:0] addr_pin_in,
    input wire logic [ppsm_pkg::HALF_W-1:0] host_port_data_wr,
    input wire logic host_port_data_drive,
    output logic [ppsm_pkg::HALF_W-1:0] host_port_data,
    output logic [ppsm_pkg::ADDR_W-1:0] host_port_address,
    input wire logic [ppsm_pkg::DATA_W-1:0] ext_mem_data_wr,
    input wire logic ext_mem_data_drive,
    output logic [ppsm_pkg::HALF_W-1:0] ext_mem_data_low,
    output logic [ppsm_pkg::HALF_W-1:0] ext_mem_data_high,
    input wire logic ext_mem_read_strobe_ctrl,
    input wire logic [ppsm_pkg::HALF_W-1:0] parallel_gpio_upper_wr,
    input wire logic [ppsm_pkg::HALF_W-1:0] parallel_gpio_upper_dir,
    output logic [ppsm_pkg::HALF_W-1:0] parallel_gpio_upper,
    input wire logic parallel_gpio_bit_twenty_wr,
    input wire logic parallel_gpio_bit_twenty_dir,
    output logic parallel_gpio_bit_twenty,
    output logic ext_mem_mode,
    output logic host_nonmux_mode,
    output logic port_active
);
    import ppsm_pkg::*;

    typedef struct packed {
        ppsm_phase_type phase;
        logic mode;
        logic holder_en;
        logic [DATA_W-1:0] dout;
        logic [DATA_W-1:0] doe_n;
        logic cout;
        logic coe_n;
        logic [HALF_W-1:0] hp_data;
        logic [ADDR_W-1:0] hp_addr;
        logic [DATA_W-1:0] em_data;
        logic [HALF_W-1:0] gpio_up;
        logic gpio20;
    } ppsm_state_type;

    localparam ppsm_state_type ST_RESET = '{
        phase: PH_RESET,
        mode: MODE_RESET,
        holder_en: HOLD_RESET,
        dout: '0,
        doe_n: '1,
        cout: CTRL_IDLE,
        coe_n: OE_OFF,
        hp_data: '0,
        hp_addr: '0,
        em_data: '0,
        gpio_up: '0,
        gpio20: 1'h0
    };

    ppsm_state_type st_ff;
    ppsm_state_type nxt_st;
    logic run;

    assign run = (st_ff.phase == PH_RUN);

    always_comb begin
        nxt_st = st_ff;
        // Strap sampled once, on the first edge after reset release
        case (st_ff.phase)
            PH_RESET: begin
                nxt_st.mode = mode_strap_pin;
                nxt_st.phase = PH_SETTLE;
            end
            PH_SETTLE: begin
                nxt_st.phase = PH_RUN;
            end
            PH_RUN: begin
                nxt_st.phase = PH_RUN;
            end
            default: begin
                nxt_st.phase = PH_RESET;
            end
        endcase

        // Holder setting follows the bus control bit once running
        if (run) begin
            nxt_st.holder_en = holder_enable_set;
        end

        // Pin drivers: all float until running
        nxt_st.doe_n = '1;
        nxt_st.coe_n = OE_OFF;
        nxt_st.cout = CTRL_IDLE;
        if (st_ff.phase == PH_SETTLE && st_ff.mode == MODE_EMEM) begin
            // Strobe leaves the settle phase driven at its idle level
            nxt_st.coe_n = OE_ON;
            nxt_st.cout = CTRL_IDLE;
        end
        if (run) begin
            if (st_ff.mode == MODE_EMEM) begin
                nxt_st.dout = ext_mem_data_wr;
                nxt_st.doe_n = {DATA_W{~ext_mem_data_drive}};
                nxt_st.cout = ext_mem_read_strobe_ctrl;
                nxt_st.coe_n = OE_ON;
            end else begin
                nxt_st.dout = {parallel_gpio_upper_wr, host_port_data_wr};
                nxt_st.doe_n = {~parallel_gpio_upper_dir,
                    {HALF_W{~host_port_data_drive}}};
                nxt_st.cout = parallel_gpio_bit_twenty_wr;
                nxt_st.coe_n = ~parallel_gpio_bit_twenty_dir;
            end
        end

        // Inbound capture of the selected function only
        nxt_st.hp_data = '0;
        nxt_st.hp_addr = '0;
        nxt_st.em_data = '0;
        nxt_st.gpio_up = '0;
        nxt_st.gpio20 = 1'h0;
        if (run) begin
            if (st_ff.mode == MODE_EMEM) begin
                nxt_st.em_data = data_pin_in;
            end else begin
                nxt_st.hp_data = data_pin_in[HALF_W-1:0];
                nxt_st.hp_addr = addr_pin_in;
                nxt_st.gpio_up = data_pin_in[DATA_W-1:HALF_W];
                nxt_st.gpio20 = ctrl_pin_in;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign data_pin_out = st_ff.dout;
    assign data_pin_oe_n = st_ff.doe_n;
    assign ctrl_pin_out = st_ff.cout;
    assign ctrl_pin_oe_n = st_ff.coe_n;
    assign host_port_data = st_ff.hp_data;
    assign host_port_address = st_ff.hp_addr;
    assign ext_mem_data_low = st_ff.em_data[HALF_W-1:0];
    assign ext_mem_data_high = st_ff.em_data[DATA_W-1:HALF_W];
    assign parallel_gpio_upper = st_ff.gpio_up;
    assign parallel_gpio_bit_twenty = st_ff.gpio20;
    assign ext_mem_mode = st_ff.mode;
    assign host_nonmux_mode = (st_ff.mode == MODE_HOST);
    assign port_active = run;

    // Keepers on both halves of the data bus
    ppsm_bus_holder #(.W(HALF_W)) u_hold_low (
        .clk(clk),
        .rst_n(rst_n),
        .enable(st_ff.holder_en),
        .pin_out(st_ff.dout[HALF_W-1:0]),
        .pin_oe_n(st_ff.doe_n[HALF_W-1:0]),
        .pin_in(data_pin_in[HALF_W-1:0]),
        .keep_val(data_keep_val[HALF_W-1:0]),
        .keep_on(data_keep_on[HALF_W-1:0])
    );

    ppsm_bus_holder #(.W(HALF_W)) u_hold_high (
        .clk(clk),
        .rst_n(rst_n),
        .enable(st_ff.holder_en),
        .pin_out(st_ff.dout[DATA_W-1:HALF_W]),
        .pin_oe_n(st_ff.doe_n[DATA_W-1:HALF_W]),
        .pin_in(data_pin_in[DATA_W-1:HALF_W]),
        .keep_val(data_keep_val[DATA_W-1:HALF_W]),
        .keep_on(data_keep_on[DATA_W-1:HALF_W])
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_strap_capture_edge: assert property (
        (st_ff.phase == PH_RESET) |=> (ext_mem_mode == $past(mode_strap_pin)))
        else $error("strap not captured on release edge");

    a_mode_held_fixed: assert property (
        (st_ff.phase != PH_RESET) |=> $stable(ext_mem_mode))
        else $error("latched mode changed after release");

    a_pins_float_early: assert property (
        (st_ff.phase == PH_RESET) |-> (data_pin_oe_n == '1) && ctrl_pin_oe_n)
        else $error("pin driven before function latched");

    a_host_low_route: assert property (
        run && !st_ff.mode && host_port_data_drive
        |=> (data_pin_out[HALF_W-1:0] == $past(host_port_data_wr))
            && (data_pin_oe_n[HALF_W-1:0] == '0))
        else $error("host data not routed to low pins");

    a_emem_full_route: assert property (
        run && st_ff.mode && ext_mem_data_drive
        |=> (data_pin_out == $past(ext_mem_data_wr)) && (data_pin_oe_n == '0))
        else $error("memory data not routed to pins");

    a_emem_inputs_idle: assert property (
        run && st_ff.mode && !ext_mem_data_drive |=> (data_pin_oe_n == '1))
        else $error("memory data lines not inputs");

    a_gpio_high_route: assert property (
        run && !st_ff.mode
        |=> (data_pin_oe_n[DATA_W-1:HALF_W] == ~$past(parallel_gpio_upper_dir))
            && (parallel_gpio_upper == $past(data_pin_in[DATA_W-1:HALF_W])))
        else $error("upper gpio not routed");

    a_strobe_idle_high: assert property (
        (st_ff.phase == PH_SETTLE) && st_ff.mode
        |=> !ctrl_pin_oe_n && ctrl_pin_out ##1 !ctrl_pin_oe_n)
        else $error("strobe not driven idle after reset");

    a_ctrl_gpio_dir: assert property (
        run && !st_ff.mode && !parallel_gpio_bit_twenty_dir |=> ctrl_pin_oe_n)
        else $error("gpio 20 driven while input");

    a_host_address_bus: assert property (
        run && !st_ff.mode |=> (host_port_address == $past(addr_pin_in)) && host_nonmux_mode)
        else $error("host address not taken from address pins");

    a_holder_follows: assert property (
        run |=> (st_ff.holder_en == $past(holder_enable_set)))
        else $error("holder setting not followed");

    a_emem_strobe_route: assert property (
        run && st_ff.mode
        |=> (ctrl_pin_out == $past(ext_mem_read_strobe_ctrl)) && !ctrl_pin_oe_n)
        else $error("memory strobe not routed to control pin");

    a_gpio20_route: assert property (
        run && !st_ff.mode
        |=> (ctrl_pin_out == $past(parallel_gpio_bit_twenty_wr))
            && (parallel_gpio_bit_twenty == $past(ctrl_pin_in)))
        else $error("gpio 20 not routed to control pin");

    a_host_data_inputs: assert property (
        run && !st_ff.mode && !host_port_data_drive
        |=> (data_pin_oe_n[HALF_W-1:0] == '1))
        else $error("host data lines driven while idle");

    a_upper_gpio_inputs: assert property (
        run && !st_ff.mode && (parallel_gpio_upper_dir == '0)
        |=> (data_pin_oe_n[DATA_W-1:HALF_W] == '1))
        else $error("upper gpio driven while inputs");

    a_host_data_capture: assert property (
        run && !st_ff.mode
        |=> (host_port_data == $past(data_pin_in[HALF_W-1:0])))
        else $error("host word not taken from low pins");

    a_emem_data_capture: assert property (
        run && st_ff.mode
        |=> ({ext_mem_data_high, ext_mem_data_low} == $past(data_pin_in)))
        else $error("memory data not taken from pins");

    a_unselected_zero: assert property (
        run && st_ff.mode
        |=> (host_port_data == '0) && (host_port_address == '0)
            && (parallel_gpio_upper == '0))
        else $error("host functions active in memory mode");

    a_settle_floats: assert property (
        (st_ff.phase == PH_SETTLE) |-> (data_pin_oe_n == '1) && ctrl_pin_oe_n)
        else $error("pin driven before function took effect");

    a_holder_reset_on: assert property (
        !run |-> (data_keep_on == '1))
        else $error("holders off before port runs");

    c_host_mode_run: cover property (run && !st_ff.mode && host_port_data_drive);
    c_emem_mode_run: cover property (run && st_ff.mode && ext_mem_data_drive);
    c_holder_off: cover property (run && !st_ff.holder_en);
    c_gpio20_out: cover property (run && !st_ff.mode && !ctrl_pin_oe_n);
    c_strap_mem_latch: cover property ((st_ff.phase == PH_SETTLE) && st_ff.mode);
endmodule : ppsm_strap_mux

/* src/ppsm_pkg.sv */
// Constants and types for the parallel port strap multiplexer
package ppsm_pkg;
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int ADDR_W = 16;
    localparam logic MODE_HOST = 1'h0;
    localparam logic MODE_EMEM = 1'h1;
    localparam logic OE_ON = 1'h0;
    localparam logic OE_OFF = 1'h1;
    localparam logic CTRL_IDLE = 1'h1;
    localparam logic HOLD_RESET = 1'h1;
    localparam logic MODE_RESET = 1'h0;

    typedef enum logic [2:0] {
        PH_RESET = 3'h1,
        PH_SETTLE = 3'h2,
        PH_RUN = 3'h4
    } ppsm_phase_type;
endpackage : ppsm_pkg

/* src/ppsm_bus_holder.sv */
// Bus keeper for a group of tri-state data lines
`timescale 1ns/100ps
module ppsm_bus_holder #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe_n,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] keep_val,
    output logic [W-1:0] keep_on
);
    import ppsm_pkg::*;

    typedef struct packed {
        logic [W-1:0] last;
    } ppsm_hold_type;

    ppsm_hold_type st_ff;
    ppsm_hold_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        // Track level last put on each line, by us or by the far side
        for (int i = 0; i < W; i++) begin
            if (pin_oe_n[i] == OE_ON) begin
                nxt_st.last[i] = pin_out[i];
            end else begin
                nxt_st.last[i] = pin_in[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign keep_val = st_ff.last;
    // Keeper acts only on lines we do not drive
    assign keep_on = {W{enable}} & pin_oe_n;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_keep_last_level: assert property (
        (pin_oe_n[0] == OE_ON) |=> (keep_val[0] == $past(pin_out[0])))
        else $error("keeper lost last driven level");
endmodule : ppsm_bus_holder

/* testbench/ppsm_far_side.sv */
// Far side of the parallel port pins: host or memory devices
`timescale 1ns/100ps
module ppsm_far_side (
    input wire logic clk,
    input wire logic far_en,
    input wire logic [31:0] far_val,
    input wire logic far_c_en,
    input wire logic far_c_val,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe_n,
    input wire logic [31:0] keep_val,
    input wire logic [31:0] keep_on,
    input wire logic c_out,
    input wire logic c_oe_n,
    output logic [31:0] pin_in,
    output logic c_in
);
    logic [31:0] last;
    logic last_c;
    always @(posedge clk) begin
        last <= pin_in;
        last_c <= c_in;
    end
    // Far value or keeper level on undriven data pins; floating lines wander
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
            else if (far_en) pin_in[i] = far_val[i];
            else if (keep_on[i]) pin_in[i] = keep_val[i];
            else pin_in[i] = ~last[i];
        end
        c_in = !c_oe_n ? c_out : far_c_en ? far_c_val : ~last_c;
    end
endmodule : ppsm_far_side

/* testbench/ppsm_strap_mux_tb.sv */
// Self-checking bench for the parallel port strap multiplexer
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module ppsm_strap_mux_tb;
    import ppsm_pkg::*;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic strap = 1'h0;
    logic hold_en = 1'h1;
    logic [31:0] pin_in, pin_out, pin_oe_n, keep_val, keep_on;
    logic c_in, c_out, c_oe_n, g20_rd, em_mode, nonmux, active;
    logic [15:0] hp_rd, ha_rd, em_lo, em_hi, gp_rd;
    logic [15:0] addr = 16'h0, hp_wr = 16'h0, gp_wr = 16'h0, gp_dir = 16'h0;
    logic hp_drv = 1'h0, em_drv = 1'h0, strobe = 1'h1, g20_wr = 1'h0, g20_dir = 1'h0;
    // Far side holds control pin from the start so its level is never unknown
    logic far_en = 1'h0, far_c_en = 1'h1, far_c_val = 1'h0;
    logic [31:0] em_wr = 32'h0, far_val = 32'h0;
    int error_cnt = 0;
    int check_count = 0;
    always #5 clk = ~clk;

    ppsm_strap_mux dut (.clk(clk), .rst_n(rst_n), .mode_strap_pin(strap),
        .holder_enable_set(hold_en), .data_pin_in(pin_in), .data_pin_out(pin_out),
        .data_pin_oe_n(pin_oe_n), .data_keep_val(keep_val), .data_keep_on(keep_on),
        .ctrl_pin_in(c_in), .ctrl_pin_out(c_out), .ctrl_pin_oe_n(c_oe_n),
        .addr_pin_in(addr), .host_port_data_wr(hp_wr), .host_port_data_drive(hp_drv),
        .host_port_data(hp_rd), .host_port_address(ha_rd), .ext_mem_data_wr(em_wr),
        .ext_mem_data_drive(em_drv), .ext_mem_data_low(em_lo), .ext_mem_data_high(em_hi),
        .ext_mem_read_strobe_ctrl(strobe), .parallel_gpio_upper_wr(gp_wr),
        .parallel_gpio_upper_dir(gp_dir), .parallel_gpio_upper(gp_rd),
        .parallel_gpio_bit_twenty_wr(g20_wr), .parallel_gpio_bit_twenty_dir(g20_dir),
        .parallel_gpio_bit_twenty(g20_rd), .ext_mem_mode(em_mode),
        .host_nonmux_mode(nonmux), .port_active(active));

    ppsm_far_side far (.clk(clk), .far_en(far_en), .far_val(far_val),
        .far_c_en(far_c_en), .far_c_val(far_c_val), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .keep_val(keep_val), .keep_on(keep_on), .c_out(c_out),
        .c_oe_n(c_oe_n), .pin_in(pin_in), .c_in(c_in));

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    // Strap flips right after the sampling edge; mode must not follow
    task automatic do_reset(input logic s);
        rst_n = 1'h0;
        strap = s;
        step(20);
        `CHK(pin_oe_n, 32'hFFFFFFFF)
        `CHK(c_oe_n, OE_OFF)
        `CHK(keep_on, 32'hFFFFFFFF)
        rst_n = 1'h1;
        step(1);
        strap = ~s;
        step(2);
        `CHK(em_mode, s)
        `CHK(active, 1'h1)
    endtask : do_reset

    task automatic test_host;
        do_reset(MODE_HOST);
        `CHK({em_mode, nonmux}, 2'h1)
        `CHK(pin_oe_n, 32'hFFFFFFFF)
        `CHK(c_oe_n, OE_OFF)
        far_en = 1'h1;
        far_val = 32'hA5C39E17;
        addr = 16'h4B2D;
        far_c_en = 1'h1;
        far_c_val = 1'h1;
        step(2);
        `CHK(hp_rd, 16'h9E17)
        `CHK(gp_rd, 16'hA5C3)
        `CHK(ha_rd, 16'h4B2D)
        `CHK({em_hi, em_lo}, 32'h0)
        `CHK(g20_rd, 1'h1)
        far_en = 1'h0;
        far_c_en = 1'h0;
        hp_drv = 1'h1;
        hp_wr = 16'h3C5A;
        gp_dir = 16'hFFFF;
        gp_wr = 16'h0F1E;
        g20_dir = 1'h1;
        em_drv = 1'h1;
        em_wr = 32'hFFFFFFFF;
        step(1);
        `CHK(pin_out, 32'h0F1E3C5A)
        `CHK(pin_oe_n, 32'h0)
        `CHK({c_out, c_oe_n}, 2'h0)
        hp_drv = 1'h0;
        gp_dir = 16'h0;
        g20_dir = 1'h0;
        em_drv = 1'h0;
        step(2);
        `CHK(keep_on, 32'hFFFFFFFF)
        `CHK(keep_val, 32'h0F1E3C5A)
        `CHK(pin_in, 32'h0F1E3C5A)
        hold_en = 1'h0;
        step(1);
        `CHK(keep_on, 32'h0)
        hold_en = 1'h1;
        $display("test_host done");
    endtask : test_host

    task automatic test_mem;
        do_reset(MODE_EMEM);
        `CHK(nonmux, 1'h0)
        `CHK({c_out, c_oe_n}, 2'h2)
        `CHK(pin_oe_n, 32'hFFFFFFFF)
        far_en = 1'h1;
        far_val = 32'h6D2EB471;
        addr = 16'hFFFF;
        step(2);
        `CHK({em_hi, em_lo}, 32'h6D2EB471)
        `CHK({hp_rd, ha_rd, gp_rd}, 48'h0)
        far_en = 1'h0;
        em_drv = 1'h1;
        em_wr = 32'hC0DE5A17;
        strobe = 1'h0;
        hp_drv = 1'h1;
        gp_dir = 16'hFFFF;
        g20_dir = 1'h1;
        g20_wr = 1'h1;
        step(1);
        `CHK(pin_out, 32'hC0DE5A17)
        `CHK(pin_oe_n, 32'h0)
        `CHK({c_out, c_oe_n}, 2'h0)
        em_drv = 1'h0;
        hp_drv = 1'h0;
        gp_dir = 16'h0;
        g20_dir = 1'h0;
        strobe = 1'h1;
        step(1);
        `CHK(pin_oe_n, 32'hFFFFFFFF)
        `CHK({c_out, c_oe_n}, 2'h2)
        $display("test_mem done");
    endtask : test_mem

    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        test_host();
        test_mem();
        give_verdict();
    end
endmodule : ppsm_strap_mux_tb
